// ### core/mem_bus_cycle_timing.sv
// Memory bus cycle sequencer: reset entry and exit, prefix and column part, strobe placement.
// What this block does
// - Release the address bus 3-4 CPU clocks after pin reset, 10-11 via bit eight.
// - Drive other bus controls inactive after the same delay as the bus release.
// - Resume bus drive and allow the first prefix 4-5 CPU clocks after reset ends.
// - Row prefix lasts one CPU clock plus decoded row time plus row hold.
// - Memory column part lasts column time plus buffer and column extensions.
// - I/O-channel cycles take the extensions from the I/O extension word.
// - Reads raise the output buffer strobe at twice column time minus 2 minus read-early.
// - Writes raise the output buffer strobe at twice column time minus 2 minus write-early.
// - Early write strobe falls at the column fall position.
// - Late write strobe falls at buffer fall plus late-write plus twice extension minus 2.
// - All positions use decoded field values; only row time and column time differ from the raw encodings.
// - Strobe style set uses group select strobes, clear uses group row strobes.
// - Fault-pin package bit set takes faults from the dedicated fault pin.
// - Fault-pin package bit clear takes faults from bus bit eight.
// - On writes the early write strobe rises when the row prefix ends.
// - Refresh cycles use the timing of the group named in the control word.
// - A refresh cycle is as long as a row cycle.
// - VRAM access puts the special function pin in row state soon after row rise.
// - VRAM access switches that pin to column state one clock before column part.
// - The pin stays in column state at most one CPU clock after column rise.
// - Special function pin stays low on accesses to other groups.
`timescale 1ns/1ps
`include "mem_bus_consts.svh"
module mem_bus_cycle_timing (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_req_valid,
  input wire logic [1:0] i_req_group,
  input wire logic i_req_write,
  input wire logic i_req_io,
  input wire logic i_req_refresh,
  input wire logic [31:0] i_req_addr,
  output logic o_req_ready,
  input wire logic i_reset_pin_n,
  input wire logic i_bus_bit_eight,
  input wire logic i_fault_input_pin_n,
  output logic [31:0] o_ad_out,
  output logic o_ad_oe,
  output logic [3:0] o_group_row_strobe_n,
  output logic [3:0] o_group_select_strobe_n,
  output logic o_cas_n,
  output logic o_data_output_buffer_strobe_n,
  output logic o_early_write_strobe_n,
  output logic o_late_write_strobe_n,
  output logic o_special_function_pin,
  output logic o_fault_req
);
  mem_bus_pkg::bus_state_t state_q, state_d;
  logic phase_q, phase_d, cpu_en;
  logic [7:0] cnt_q, cnt_d;
  logic [3:0] rcnt_q, rcnt_d, rlim_q, rlim_d;
  logic [1:0] pin_cnt_q, pin_cnt_d, grp_q, grp_d;
  logic wr_q, wr_d, io_q, io_d, ref_q, ref_d, ready_d;
  logic [31:0] addr_q, addr_d;
  logic pin_rst, bit8_rst, accept;
  logic [127:0] grp_words;
  logic [31:0] io_ext, ctrl, grp_word;
  logic [7:0] pre_len, ras_fall, cas_len, cas_fall, cas_rise;
  logic [7:0] dob_fall, dob_rise_rd, dob_rise_wr, lwe_fall, dob_rise;

  mem_bus_regs u_regs (
    .i_mclk(i_mclk),
    .i_rstn(i_rstn),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .i_status({4'h0, o_ad_oe, state_q}),
    .o_rdata(o_rdata),
    .o_grp(grp_words),
    .o_io_ext(io_ext),
    .o_ctrl(ctrl)
  );

  // The latched group picks its timing word for the whole cycle.
  assign grp_word = grp_words[{grp_q, 5'h00} +: 32];

  timing_field_decode u_dec (
    .i_grp(grp_word),
    .i_io(io_ext),
    .i_io_sel(io_q),
    .o_pre_len(pre_len),
    .o_ras_fall(ras_fall),
    .o_cas_len(cas_len),
    .o_cas_fall(cas_fall),
    .o_cas_rise(cas_rise),
    .o_dob_fall(dob_fall),
    .o_dob_rise_rd(dob_rise_rd),
    .o_dob_rise_wr(dob_rise_wr),
    .o_lwe_fall(lwe_fall)
  );

  // Reset sources: the pin counts in CPU clocks, bus bit eight acts only when idle and enabled.
  assign cpu_en = phase_q;
  assign pin_rst = (pin_cnt_q == `RST_PIN_MIN);
  assign bit8_rst = ctrl[`C_AD8RST] & ~i_bus_bit_eight & (state_q == mem_bus_pkg::ST_IDLE);
  assign accept = i_req_valid & o_req_ready;

  // Sequencer next state: all bus cycles start on a CPU clock boundary.
  always_comb begin
    state_d = state_q;
    phase_d = ~phase_q;
    cnt_d = cnt_q;
    rcnt_d = rcnt_q;
    rlim_d = rlim_q;
    pin_cnt_d = pin_cnt_q;
    grp_d = grp_q;
    wr_d = wr_q;
    io_d = io_q;
    ref_d = ref_q;
    addr_d = addr_q;
    // A released pin clears the count at once, so a stale count cannot re-enter reset on exit.
    if (i_reset_pin_n) begin
      pin_cnt_d = 2'h0;
    end else if (cpu_en && !pin_rst) begin
      pin_cnt_d = pin_cnt_q + 2'h1;
    end
    case (state_q)
      mem_bus_pkg::ST_IDLE: begin
        if (accept) begin
          state_d = mem_bus_pkg::ST_PREFIX;
          cnt_d = 8'h00;
          grp_d = i_req_refresh ? ctrl[`C_RFGRP +: 2] : i_req_group;
          wr_d = i_req_write & ~i_req_refresh;
          io_d = i_req_io & ~i_req_refresh;
          ref_d = i_req_refresh;
          addr_d = i_req_addr;
        end
      end
      mem_bus_pkg::ST_PREFIX: begin
        if (cnt_q == pre_len - 8'h01) begin
          state_d = mem_bus_pkg::ST_CASP;
          cnt_d = 8'h00;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      mem_bus_pkg::ST_CASP: begin
        if (cnt_q == cas_len - 8'h01) begin
          state_d = mem_bus_pkg::ST_IDLE;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      mem_bus_pkg::ST_RST_ENTER: begin
        if (cpu_en) begin
          if (rcnt_q == rlim_q) begin
            state_d = mem_bus_pkg::ST_RST_HOLD;
          end else begin
            rcnt_d = rcnt_q + 4'h1;
          end
        end
      end
      mem_bus_pkg::ST_RST_HOLD: begin
        if (i_reset_pin_n && i_bus_bit_eight) begin
          state_d = mem_bus_pkg::ST_RST_EXIT;
          rcnt_d = 4'h0;
        end
      end
      mem_bus_pkg::ST_RST_EXIT: begin
        if (cpu_en) begin
          if (rcnt_q == `RST_EXIT - 4'h1) begin
            state_d = mem_bus_pkg::ST_IDLE;
          end else begin
            rcnt_d = rcnt_q + 4'h1;
          end
        end
      end
      default: begin
        state_d = mem_bus_pkg::ST_IDLE;
      end
    endcase
    // The pin has already spent its recognition clocks, so it waits less than bit eight.
    if ((pin_rst || bit8_rst) && state_q != mem_bus_pkg::ST_RST_ENTER &&
        state_q != mem_bus_pkg::ST_RST_HOLD) begin
      state_d = mem_bus_pkg::ST_RST_ENTER;
      rcnt_d = 4'h0;
      rlim_d = pin_rst ? (`RST_PIN_REL - {2'h0, `RST_PIN_MIN} - 4'h1) : (`RST_AD8_REL - 4'h1);
    end
    ready_d = (state_d == mem_bus_pkg::ST_IDLE) & phase_d & ~pin_rst & ~bit8_rst;
  end

  // Sequencer registers; after power-up the exit delay runs before the first cycle.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_q <= mem_bus_pkg::ST_RST_EXIT;
      phase_q <= 1'b0;
      cnt_q <= 8'h00;
      rcnt_q <= 4'h0;
      rlim_q <= 4'h0;
      pin_cnt_q <= 2'h0;
      grp_q <= 2'h0;
      wr_q <= 1'b0;
      io_q <= 1'b0;
      ref_q <= 1'b0;
      addr_q <= 32'h0000_0000;
      o_req_ready <= 1'b0;
    end else begin
      state_q <= state_d;
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      rcnt_q <= rcnt_d;
      rlim_q <= rlim_d;
      pin_cnt_q <= pin_cnt_d;
      grp_q <= grp_d;
      wr_q <= wr_d;
      io_q <= io_d;
      ref_q <= ref_d;
      addr_q <= addr_d;
      o_req_ready <= ready_d;
    end
  end

  logic in_pre, in_cas, ras_low, vram, col_ph;
  logic [3:0] row_n_d, sel_n_d;
  logic cas_n_d, dob_n_d, ewe_n_d, lwe_n_d, dsf_d, fault_d, oe_d;
  logic [31:0] ad_d;

  // Per-group strobe fan-out; only the style chosen in control moves.
  for (genvar g = 0; g < 4; g++) begin : g_strobe
    assign row_n_d[g] = ~(ras_low & (grp_q == 2'(g)) & ~ctrl[`C_STYLE]);
    assign sel_n_d[g] = ~(ras_low & (grp_q == 2'(g)) & ctrl[`C_STYLE]);
  end

  // Strobe shapes from the position counter, one clock ahead of the pins.
  always_comb begin
    in_pre = (state_q == mem_bus_pkg::ST_PREFIX);
    in_cas = (state_q == mem_bus_pkg::ST_CASP);
    ras_low = (in_pre & (cnt_q >= ras_fall)) | in_cas;
    dob_rise = wr_q ? dob_rise_wr : dob_rise_rd;
    cas_n_d = ~(in_cas & ~ref_q & (cnt_q >= cas_fall) & (cnt_q < cas_rise));
    dob_n_d = ~(in_cas & ~ref_q & (cnt_q >= dob_fall) & (cnt_q < dob_rise));
    ewe_n_d = ~(wr_q & (in_pre | (in_cas & (cnt_q >= cas_fall) & (cnt_q < dob_rise_wr))));
    lwe_n_d = ~(wr_q & in_cas & (cnt_q >= lwe_fall) & (cnt_q < dob_rise_wr));
    vram = (grp_q == ctrl[`C_VRGRP +: 2]) & ~ref_q;
    col_ph = (in_pre & (cnt_q == pre_len - 8'h01)) | (in_cas & (cnt_q < cas_rise + 8'h02));
    dsf_d = 1'b0;
    if (vram && col_ph) begin
      dsf_d = ctrl[`C_DSF_COL];
    end else if (vram && in_pre && cnt_q >= `RAS_RISE_2X) begin
      dsf_d = ctrl[`C_DSF_ROW];
    end
    fault_d = (in_pre | in_cas) &
              (ctrl[`C_PKGFLT] ? ~i_fault_input_pin_n : ~i_bus_bit_eight);
    oe_d = (state_q != mem_bus_pkg::ST_RST_HOLD) && (state_q != mem_bus_pkg::ST_RST_EXIT);
    ad_d = (in_pre | in_cas) ? addr_q : o_ad_out;
  end

  // Pins freeze while reset entry counts, so release and deactivation come together.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_ad_out <= 32'h0000_0000;
      o_ad_oe <= 1'b0;
      o_group_row_strobe_n <= 4'hf;
      o_group_select_strobe_n <= 4'hf;
      o_cas_n <= 1'b1;
      o_data_output_buffer_strobe_n <= 1'b1;
      o_early_write_strobe_n <= 1'b1;
      o_late_write_strobe_n <= 1'b1;
      o_special_function_pin <= 1'b0;
      o_fault_req <= 1'b0;
    end else if (state_q != mem_bus_pkg::ST_RST_ENTER) begin
      o_ad_out <= ad_d;
      o_ad_oe <= oe_d;
      o_group_row_strobe_n <= row_n_d;
      o_group_select_strobe_n <= sel_n_d;
      o_cas_n <= cas_n_d;
      o_data_output_buffer_strobe_n <= dob_n_d;
      o_early_write_strobe_n <= ewe_n_d;
      o_late_write_strobe_n <= lwe_n_d;
      o_special_function_pin <= dsf_d;
      o_fault_req <= fault_d;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  sequence enter_from_pin;
    (state_q != mem_bus_pkg::ST_RST_ENTER) ##1 (state_q == mem_bus_pkg::ST_RST_ENTER) &&
      (rlim_q == 4'h0);
  endsequence
  sequence enter_from_bit8;
    (state_q != mem_bus_pkg::ST_RST_ENTER) ##1 (state_q == mem_bus_pkg::ST_RST_ENTER) &&
      (rlim_q == 4'h9);
  endsequence

  chk_pin_release: assert property (enter_from_pin |-> ##[1:4] !o_ad_oe)
    else $error("bus not released after pin reset");
  chk_bit8_release: assert property (enter_from_bit8 |-> ##[17:22] (!o_ad_oe && o_cas_n))
    else $error("bus not released after bit eight reset");
  chk_exit_resume: assert property ($rose(state_q == mem_bus_pkg::ST_RST_EXIT) |->
      !o_ad_oe[*6] ##[1:4] o_ad_oe)
    else $error("bus drive not resumed in time after reset");
  chk_prefix_len: assert property (in_pre && state_d == mem_bus_pkg::ST_CASP |->
      cnt_q == pre_len - 8'h01)
    else $error("row prefix length wrong");
  chk_cas_len: assert property (in_cas && state_d == mem_bus_pkg::ST_IDLE |->
      cnt_q == cas_len - 8'h01)
    else $error("column part length wrong");
  chk_dob_read: assert property (in_cas && !wr_q && cnt_q == dob_rise_rd && dob_rise_rd > 0 |=>
      o_data_output_buffer_strobe_n)
    else $error("buffer strobe not raised on read");
  chk_dob_write: assert property (in_cas && wr_q && cnt_q == dob_rise_wr && dob_rise_wr > 0 |=>
      o_data_output_buffer_strobe_n)
    else $error("buffer strobe not raised on write");
  chk_ewe_fall: assert property (in_cas && wr_q && cnt_q == cas_fall && cas_fall < dob_rise_wr
      |=> !o_early_write_strobe_n)
    else $error("early write strobe not low at column fall");
  chk_lwe_fall: assert property (in_cas && wr_q && cnt_q == lwe_fall && lwe_fall < dob_rise_wr
      |=> !o_late_write_strobe_n)
    else $error("late write strobe not low at its fall position");
  chk_strobe_style: assert property ($past(ctrl[`C_STYLE]) && $past(state_q) !=
      mem_bus_pkg::ST_RST_ENTER |-> &o_group_row_strobe_n)
    else $error("row strobe moved while select style chosen");
  chk_fault_bit8: assert property ((in_pre || in_cas) && !ctrl[`C_PKGFLT] && !i_bus_bit_eight
      |=> o_fault_req)
    else $error("fault from bus bit eight lost");
  chk_dsf_other: assert property (in_pre && !vram |=> !o_special_function_pin)
    else $error("special function pin high on other group");
endmodule // mem_bus_cycle_timing

// ### core/mem_bus_consts.svh
// Register offsets, field positions, reset values and timing counts of the memory bus timer.
`ifndef MEM_BUS_CONSTS_SVH
`define MEM_BUS_CONSTS_SVH
`define MB_OFF_GRP0 8'h00
`define MB_OFF_GRP1 8'h04
`define MB_OFF_GRP2 8'h08
`define MB_OFF_GRP3 8'h0c
`define MB_OFF_IOEXT 8'h10
`define MB_OFF_CTRL 8'h14
`define MB_OFF_STATUS 8'h18
// Group timing word: raw encodings, decoded by the field decoder.
`define F_RAS 0
`define F_RHLD 3
`define F_CAST 6
`define F_DOBE 9
`define F_CASE 12
`define F_ERAS 15
`define F_EOE 16
`define F_EWE 17
`define F_CASF 18
`define F_DOB 21
`define F_LWEA 24
// I/O-channel extension word.
`define F_IO_DOBE 0
`define F_IO_CASE 3
// Control word bits.
`define C_STYLE 0
`define C_PKGFLT 1
`define C_RFGRP 2
`define C_VRGRP 4
`define C_DSF_ROW 6
`define C_DSF_COL 7
`define C_AD8RST 8
`define MB_GRP_RESET 32'h0000_0000
`define MB_CTRL_RESET 32'h0000_0002
// Reset timing in CPU clocks.
`define RST_PIN_MIN 2'h2
`define RST_PIN_REL 4'h3
`define RST_AD8_REL 4'ha
`define RST_EXIT 4'h4
// Double-rate clocks from prefix start to the row strobe going inactive.
`define RAS_RISE_2X 8'h02
`endif

// ### core/mem_bus_pkg.sv
// Types shared by the memory bus timing block.
package mem_bus_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PREFIX = 3'b001,
    ST_CASP = 3'b011,
    ST_RST_ENTER = 3'b010,
    ST_RST_HOLD = 3'b110,
    ST_RST_EXIT = 3'b111
  } bus_state_t;
endpackage

// ### core/mem_bus_regs.sv
// Register file of the memory bus timer: four group timing words, I/O extension, control.
`timescale 1ns/1ps
`include "mem_bus_consts.svh"
module mem_bus_regs (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_status,
  output logic [31:0] o_rdata,
  output logic [127:0] o_grp,
  output logic [31:0] o_io_ext,
  output logic [31:0] o_ctrl
);
  logic [127:0] grp_d;
  logic [31:0] io_d, ctrl_d, rdata_d;

  // Writes land in the addressed word; reads answer the next cycle, unmapped reads give zero.
  always_comb begin
    grp_d = o_grp;
    io_d = o_io_ext;
    ctrl_d = o_ctrl;
    rdata_d = 32'h0000_0000;
    for (int g = 0; g < 4; g++) begin
      if (i_wr && i_addr == 8'(g * 4)) begin
        grp_d[g*32 +: 32] = i_wdata;
      end
      if (i_rd && i_addr == 8'(g * 4)) begin
        rdata_d = o_grp[g*32 +: 32];
      end
    end
    if (i_wr && i_addr == `MB_OFF_IOEXT) io_d = i_wdata;
    if (i_wr && i_addr == `MB_OFF_CTRL) ctrl_d = i_wdata;
    if (i_rd && i_addr == `MB_OFF_IOEXT) rdata_d = o_io_ext;
    if (i_rd && i_addr == `MB_OFF_CTRL) rdata_d = o_ctrl;
    if (i_rd && i_addr == `MB_OFF_STATUS) rdata_d = {24'h00_0000, i_status};
  end

  // Plain registers.
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_grp <= {4{`MB_GRP_RESET}};
      o_io_ext <= 32'h0000_0000;
      o_ctrl <= `MB_CTRL_RESET;
      o_rdata <= 32'h0000_0000;
    end else begin
      o_grp <= grp_d;
      o_io_ext <= io_d;
      o_ctrl <= ctrl_d;
      o_rdata <= rdata_d;
    end
  end
endmodule // mem_bus_regs

// ### core/timing_field_decode.sv
// Turns raw group timing fields into strobe positions counted in double-rate clocks.
`timescale 1ns/1ps
`include "mem_bus_consts.svh"
module timing_field_decode (
  input wire logic [31:0] i_grp,
  input wire logic [31:0] i_io,
  input wire logic i_io_sel,
  output logic [7:0] o_pre_len,
  output logic [7:0] o_ras_fall,
  output logic [7:0] o_cas_len,
  output logic [7:0] o_cas_fall,
  output logic [7:0] o_cas_rise,
  output logic [7:0] o_dob_fall,
  output logic [7:0] o_dob_rise_rd,
  output logic [7:0] o_dob_rise_wr,
  output logic [7:0] o_lwe_fall
);
  // A time of zero would mean an empty phase, so row time and column time decode as raw plus one; other fields stay raw.
  function automatic logic [7:0] dec3(input logic [2:0] raw, input logic bias);
    return {5'h00, raw} + {7'h00, bias};
  endfunction

  // Positions never go below zero, so short settings clamp instead of wrapping.
  function automatic logic [7:0] sub_sat(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a - b : 8'h00;
  endfunction

  logic [7:0] ras, rhld, cast, dobe, cse, eras, eoe, early_write_strobe, lwea;

  always_comb begin
    ras = dec3(i_grp[`F_RAS +: 3], 1'b1);
    rhld = dec3(i_grp[`F_RHLD +: 3], 1'b0);
    cast = dec3(i_grp[`F_CAST +: 3], 1'b1);
    dobe = i_io_sel ? dec3(i_io[`F_IO_DOBE +: 3], 1'b0) : dec3(i_grp[`F_DOBE +: 3], 1'b0);
    cse = i_io_sel ? dec3(i_io[`F_IO_CASE +: 3], 1'b0) : dec3(i_grp[`F_CASE +: 3], 1'b0);
    eras = {7'h00, i_grp[`F_ERAS]};
    eoe = {7'h00, i_grp[`F_EOE]};
    early_write_strobe = {7'h00, i_grp[`F_EWE]};
    lwea = dec3({1'b0, i_grp[`F_LWEA +: 2]}, 1'b0);
    o_pre_len = 8'h02 + (ras << 1) + (rhld << 1);
    o_ras_fall = sub_sat(`RAS_RISE_2X + (ras << 1), eras);
    o_cas_len = (cast + dobe + cse) << 1;
    o_cas_fall = dec3(i_grp[`F_CASF +: 3], 1'b0);
    o_cas_rise = cast << 1;
    o_dob_fall = dec3(i_grp[`F_DOB +: 3], 1'b0);
    o_dob_rise_rd = sub_sat(cast << 1, 8'h02 + eoe);
    o_dob_rise_wr = sub_sat(cast << 1, 8'h02 + early_write_strobe);
    o_lwe_fall = sub_sat(o_dob_fall + lwea + (dobe << 1), 8'h02);
  end
endmodule // timing_field_decode

// ### verification/ext_memory_model.sv
// Model of the external memory and fault source on the far side of the bus.
`timescale 1ns/1ps
module ext_memory_model (
  input wire logic i_mclk,
  input wire logic [1:0] i_mode,
  input wire logic [3:0] i_row_n,
  input wire logic [3:0] i_sel_n,
  input wire logic i_ad_oe,
  input wire logic [31:0] i_ad_out,
  output logic o_fault_n,
  output logic o_bit_eight
);
  logic held_q = 1'b1;
  logic busy;

  // A fault is only signalled inside an access, as a real memory would do it.
  assign busy = (&i_row_n == 1'b0) || (&i_sel_n == 1'b0);
  assign o_fault_n = !(i_mode == 2'h1 && busy);

  // Bus repeaters keep the last level; the reset source leaves bit eight high.
  always_ff @(posedge i_mclk) begin
    if (i_mode == 2'h3) begin
      held_q <= 1'b1;
    end else if (i_ad_oe) begin
      held_q <= i_ad_out[8];
    end
  end

  // Mode 2 pulls bit eight low in an access, mode 3 holds it low as a reset.
  always_comb begin
    if (i_mode == 2'h3 || (i_mode == 2'h2 && busy)) begin
      o_bit_eight = 1'b0;
    end else if (i_ad_oe) begin
      o_bit_eight = i_ad_out[8];
    end else begin
      o_bit_eight = held_q;
    end
  end
endmodule // ext_memory_model

// ### verification/mem_bus_cycle_timing_bench.sv
// Self-checking bench for the memory bus cycle sequencer.
`timescale 1ns/1ps
module mem_bus_cycle_timing_bench;
  // Decoded timing of the word programmed into group 0.
  localparam int RAS = 2, RHLD = 1, CAS_TIME = 4, BUF_EXT = 1, CAS_EXT = 0, RAS_EARLY = 1;
  localparam int RD_EARLY = 1, WR_EARLY = 0, CAS_FALL = 2, BUF_FALL = 1, LATE_ADD = 1;
  localparam logic [31:0] GRP0 = 32'h0129_82c9;
  logic i_mclk = 1'b0;
  logic i_rstn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0, i_rd = 1'b0, i_req_valid = 1'b0, i_req_write = 1'b0;
  logic i_req_io = 1'b0, i_req_refresh = 1'b0, i_reset_pin_n = 1'b1;
  logic [1:0] i_req_group = 2'h0, fmode = 2'h0;
  logic [31:0] i_req_addr = 32'h0000_0100;
  logic [31:0] o_rdata, o_ad_out;
  logic o_req_ready, o_ad_oe, o_cas_n, o_data_output_buffer_strobe_n, o_early_write_strobe_n;
  logic o_late_write_strobe_n, o_special_function_pin, o_fault_req, fault_n, bit_eight;
  logic [3:0] o_group_row_strobe_n, o_group_select_strobe_n;
  int n_mismatch = 0, compares = 0;
  int c_cas, c_buf, c_row, c_sel, c_early, c_late, c_spf, c_flt;

  mem_bus_cycle_timing i_mem_bus_cycle_timing (
    .i_mclk, .i_rstn, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_req_valid,
    .i_req_group, .i_req_write, .i_req_io, .i_req_refresh, .i_req_addr, .o_req_ready,
    .i_reset_pin_n, .i_bus_bit_eight(bit_eight), .i_fault_input_pin_n(fault_n), .o_ad_out,
    .o_ad_oe, .o_group_row_strobe_n, .o_group_select_strobe_n, .o_cas_n,
    .o_data_output_buffer_strobe_n, .o_early_write_strobe_n, .o_late_write_strobe_n,
    .o_special_function_pin, .o_fault_req
  );
  ext_memory_model i_ext_memory_model (
    .i_mclk, .i_mode(fmode), .i_row_n(o_group_row_strobe_n),
    .i_sel_n(o_group_select_strobe_n), .i_ad_oe(o_ad_oe), .i_ad_out(o_ad_out),
    .o_fault_n(fault_n), .o_bit_eight(bit_eight)
  );

  // Free-running 200 MHz clock.
  initial begin
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
  endtask

  task automatic wait_oe(input logic lvl, output int k);
    k = 0;
    do begin
      @(posedge i_mclk);
      #1;
      k++;
    end while (o_ad_oe !== lvl && k < 40);
  endtask

  // One bus cycle; counting low cycles per strobe is immune to pipeline lag.
  task automatic run(input logic [1:0] g, input logic w, input logic io, input logic rf);
    int k;
    k = 0;
    {c_cas, c_buf, c_row, c_sel} = '0;
    {c_early, c_late, c_spf, c_flt} = '0;
    @(posedge i_mclk);
    i_req_valid <= 1'b1;
    i_req_group <= g;
    i_req_write <= w;
    i_req_io <= io;
    i_req_refresh <= rf;
    #1;
    while (o_req_ready !== 1'b1 && k < 100) begin
      @(posedge i_mclk);
      #1;
      k++;
    end
    chk("request taken", 1, k < 100);
    @(posedge i_mclk);
    i_req_valid <= 1'b0;
    repeat (60) begin
      @(posedge i_mclk);
      #1;
      c_cas += !o_cas_n;
      c_buf += !o_data_output_buffer_strobe_n;
      c_row += !o_group_row_strobe_n[g];
      c_sel += !o_group_select_strobe_n[g];
      c_early += !o_early_write_strobe_n;
      c_late += !o_late_write_strobe_n;
      c_spf += o_special_function_pin;
      c_flt += o_fault_req;
    end
  endtask

  task automatic t_regs();
    logic [31:0] d;
    reg_rd(8'h14, d);
    chk("ctrl reset", 32'h0000_0002, d);
    reg_rd(8'h00, d);
    chk("group0 reset", 32'h0, d);
    reg_wr(8'h1c, 32'hffff_ffff);
    reg_rd(8'h1c, d);
    chk("unmapped", 32'h0, d);
    reg_wr(8'h00, GRP0);
    reg_rd(8'h00, d);
    chk("group0", GRP0, d);
    $display("test regs done");
  endtask

  task automatic t_rw();
    run(2'h0, 1'b0, 1'b0, 1'b0);
    chk("read row", 2 * RHLD + RAS_EARLY + 2 * (CAS_TIME + BUF_EXT + CAS_EXT), c_row);
    chk("read cas", 2 * CAS_TIME - CAS_FALL, c_cas);
    chk("read buffer", 2 * CAS_TIME - 2 - RD_EARLY - BUF_FALL, c_buf);
    chk("read select", 0, c_sel);
    chk("read write strobes", 0, c_early + c_late);
    chk("address out", 32'h0000_0100, o_ad_out);
    run(2'h0, 1'b1, 1'b0, 1'b0);
    chk("write buffer", 2 * CAS_TIME - 2 - WR_EARLY - BUF_FALL, c_buf);
    chk("write early", 2 + 2 * (RAS + RHLD + CAS_TIME) - 2 - WR_EARLY - CAS_FALL, c_early);
    chk("write late", 2 * CAS_TIME - WR_EARLY - BUF_FALL - LATE_ADD - 2 * BUF_EXT, c_late);
    $display("test read write done");
  endtask

  task automatic t_modes();
    reg_wr(8'h14, 32'h0000_0003);
    run(2'h0, 1'b0, 1'b0, 1'b0);
    chk("style select", 2 * RHLD + RAS_EARLY + 2 * (CAS_TIME + BUF_EXT + CAS_EXT), c_sel);
    chk("style row", 0, c_row);
    reg_wr(8'h14, 32'h0000_000a);
    reg_wr(8'h10, 32'h0000_000a);
    run(2'h0, 1'b0, 1'b1, 1'b0);
    chk("io row", 2 * RHLD + RAS_EARLY + 2 * (CAS_TIME + 2 + 1), c_row);
    // Group 2 is still all zero: one CPU clock of row time and of column time.
    run(2'h2, 1'b0, 1'b0, 1'b1);
    chk("refresh row", 2, c_row);
    chk("refresh cas", 0, c_cas);
    $display("test modes done");
  endtask

  task automatic t_vram();
    reg_wr(8'h14, 32'h0000_00c2);
    run(2'h0, 1'b0, 1'b0, 1'b0);
    chk("vram pin", 2 * RAS + 2 * RHLD + 2 * CAS_TIME + 2, c_spf);
    reg_wr(8'h14, 32'h0000_00d2);
    run(2'h0, 1'b0, 1'b0, 1'b0);
    chk("other group pin", 0, c_spf);
    $display("test vram done");
  endtask

  // Each fault source must only count when the package bit selects it.
  task automatic t_fault();
    for (int i = 0; i < 4; i++) begin
      reg_wr(8'h14, i[1] ? 32'h0000_0002 : 32'h0000_0000);
      fmode <= i[0] ? 2'h2 : 2'h1;
      run(2'h0, 1'b0, 1'b0, 1'b0);
      fmode <= 2'h0;
      chk("fault seen", i[1] ^ i[0], c_flt != 0);
    end
    $display("test fault done");
  endtask

  task automatic t_reset();
    int k;
    @(posedge i_mclk);
    i_reset_pin_n <= 1'b0;
    wait_oe(1'b0, k);
    chk("pin release", 1, k >= 6 && k <= 10);
    chk("pin inactive", 1, &{o_group_row_strobe_n, o_group_select_strobe_n, o_cas_n,
      o_data_output_buffer_strobe_n, o_early_write_strobe_n, o_late_write_strobe_n});
    @(posedge i_mclk);
    i_reset_pin_n <= 1'b1;
    wait_oe(1'b1, k);
    chk("pin resume", 1, k >= 8 && k <= 12);
    reg_wr(8'h14, 32'h0000_0102);
    @(posedge i_mclk);
    fmode <= 2'h3;
    wait_oe(1'b0, k);
    chk("bit eight release", 1, k >= 20 && k <= 24);
    @(posedge i_mclk);
    fmode <= 2'h0;
    wait_oe(1'b1, k);
    chk("bit eight resume", 1, k >= 8 && k <= 12);
    $display("test reset done");
  endtask

  task automatic close_out();
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Main sequence; reset is released after three clock cycles.
  initial begin
    int k;
    repeat (3) @(posedge i_mclk);
    i_rstn <= 1'b1;
    wait_oe(1'b1, k);
    chk("reset exit", 1, k >= 8 && k <= 11);
    t_regs();
    t_rw();
    t_modes();
    t_vram();
    t_fault();
    t_reset();
    close_out();
  end

  // The tests need some 800 cycles; far beyond that the run is hung.
  initial begin
    #100000;
    n_mismatch++;
    close_out();
  end
endmodule // mem_bus_cycle_timing_bench
